// ---- verilog/mies_pkg.sv ----
// Operation
// - bit test skip: tested bit set drops next fetched word, two cycles
// - indirect call pushes pc+1, loads pc from pointer bits 1:0 and work
// - indirect jump loads pc from pointer bits 1:0 and work, stack untouched
// - zero_work_reg clears work register and sets zero flag
// - kick clears watchdog, divider if assigned, sets expiry and sleep bits
// - zero_file_reg clears file register and sets zero flag
// - invert_file_reg complements file register, updates zero, to destination
// - compare subtracts work from file, updates zero and carry only
// - minus_one_file_reg decrements file register, updates zero, to destination
// - minus_one_skip_zero decrements to destination, zero result drops next word
// - plus_one_file_reg increments file register, updates zero, to destination
// - plus_one_skip_zero increments to destination, zero result drops next word
// - decimal_adjust packs work register as decimal, touches carry only
// - irq_unmask_all sets global interrupt enable in one cycle
// - jump_paged loads 9-bit immediate plus latch bit 1 into pc
// - soft_trap pushes pc+1 and jumps to vector, three cycles
// - destination bit 0 selects work register, 1 selects file register
package mies_pkg;
  localparam int PC_WIDTH = 10;
  localparam int DATA_WIDTH = 8;
  localparam int INSTR_WIDTH = 14;
  localparam int FILE_DEPTH = 64;
  localparam int STACK_DEPTH = 8;
  localparam logic [9:0] PC_RESET = 10'h000;
  localparam logic [9:0] TRAP_VECTOR = 10'h001;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [2:0] SP_RESET = 3'h0;
  // field positions inside an instruction word; PAGE_BIT_POS indexes pageHighLatch
  localparam int DEST_POS = 6;
  localparam int BIT_SEL_LSB = 6;
  localparam int PAGE_BIT_POS = 1;
  // operand-free words
  localparam logic [13:0] OP_NOP = 14'h0000;
  localparam logic [13:0] OP_ZERO_WORK = 14'h0001;
  localparam logic [13:0] OP_KICK_WDOG = 14'h0002;
  localparam logic [13:0] OP_DEC_ADJUST = 14'h0003;
  localparam logic [13:0] OP_IRQ_MASK = 14'h0004;
  localparam logic [13:0] OP_IRQ_UNMASK = 14'h0005;
  localparam logic [13:0] OP_CALL_IND = 14'h0006;
  localparam logic [13:0] OP_JUMP_IND = 14'h0007;
  localparam logic [13:0] OP_SOFT_TRAP = 14'h0008;
  // file register group, code in bits 13:7
  localparam logic [6:0] RG_ZERO_FILE = 7'h01;
  localparam logic [6:0] RG_INVERT = 7'h02;
  localparam logic [6:0] RG_COMPARE = 7'h03;
  localparam logic [6:0] RG_DEC = 7'h04;
  localparam logic [6:0] RG_DEC_SKIP = 7'h05;
  localparam logic [6:0] RG_INC = 7'h06;
  localparam logic [6:0] RG_INC_SKIP = 7'h07;
  localparam logic [6:0] RG_OR = 7'h08;
  // groups with wide operands, code in bits 13:9
  localparam logic [4:0] GRP_SKIP_SET = 5'h0E;
  localparam logic [4:0] GRP_JUMP_PAGED = 5'h14;
  typedef enum logic [1:0] {RUN, DROP_ONE, TRAP_LOAD} mies_state_type;
endpackage

// ---- verilog/mies_core.sv ----
`timescale 1ns/1ps
module mies_core (
  input wire logic clk,
  input wire logic sys_rst,
  output logic [mies_pkg::PC_WIDTH-1:0] progAddr,
  input wire logic [mies_pkg::INSTR_WIDTH-1:0] progData,
  input wire logic [mies_pkg::DATA_WIDTH-1:0] tableHighPointer,
  input wire logic [mies_pkg::DATA_WIDTH-1:0] pageHighLatch,
  input wire logic dividerToWatchdog,
  input wire logic watchdogTimeout,
  input wire logic sleepEnter,
  input wire logic [5:0] peekAddr,
  output logic [mies_pkg::DATA_WIDTH-1:0] peekData,
  output logic [mies_pkg::DATA_WIDTH-1:0] workRegister,
  output logic zeroFlag,
  output logic digitCarryFlag,
  output logic carryFlag,
  output logic globalIrqEnable,
  output logic watchdogExpiry,
  output logic sleepStatus,
  output logic watchdogClear,
  output logic dividerClear
);
  import mies_pkg::*;

  mies_state_type state;
  logic [9:0] pc;
  logic [9:0] execAddr;
  logic [7:0] fileMem [FILE_DEPTH];
  logic [9:0] stackMem [STACK_DEPTH];
  logic [2:0] sp;

  // decoded view of the word now executing
  logic live;
  logic [13:0] instr;
  logic [5:0] fileIdx;
  logic [7:0] fileVal;
  logic [6:0] rgCode;
  logic [4:0] grpCode;
  logic [9:0] retAddr;
  logic [8:0] cmpSum;
  logic [8:0] adjLow;
  logic [8:0] adjAll;
  logic lowFix;
  logic highFix;

  // a dropped slot executes as a plain nop
  assign live = (state == RUN);
  assign instr = live ? progData : OP_NOP;
  assign fileIdx = instr[5:0];
  assign fileVal = fileMem[fileIdx];
  assign rgCode = instr[13:7];
  assign grpCode = instr[13:9];
  assign retAddr = execAddr + 10'h001;
  assign progAddr = pc;

  // R - ACC as R + ~ACC + 1, carry set means no borrow
  assign cmpSum = {1'b0, fileVal} + {1'b0, ~workRegister} + 9'h001;

  // decimal fix-up relies on carries left by the preceding add
  assign lowFix = (workRegister[3:0] > 4'h9) || digitCarryFlag;
  assign adjLow = {1'b0, workRegister} + (lowFix ? 9'h006 : 9'h000);
  assign highFix = carryFlag || adjLow[8] || (adjLow[7:4] > 4'h9);
  assign adjAll = adjLow + (highFix ? 9'h060 : 9'h000);

  // result steering for the file register group
  logic [7:0] result;
  logic isFileOp;
  logic toFile;
  logic toWork;
  logic updZero;
  logic skipNext;
  logic isCall;
  logic isJump;
  logic [9:0] jumpTarget;

  always_comb
  begin
    result = DATA_RESET;
    isFileOp = 1'b1;
    updZero = 1'b1;
    skipNext = 1'b0;
    unique case (rgCode)
      RG_ZERO_FILE: result = DATA_RESET;
      RG_INVERT: result = ~fileVal;
      RG_COMPARE: result = cmpSum[7:0];
      RG_DEC: result = fileVal - 8'h01;
      RG_DEC_SKIP:
      begin
        result = fileVal - 8'h01;
        updZero = 1'b0;
        skipNext = (result == DATA_RESET);
      end
      RG_INC: result = fileVal + 8'h01;
      RG_INC_SKIP:
      begin
        result = fileVal + 8'h01;
        updZero = 1'b0;
        skipNext = (result == DATA_RESET);
      end
      RG_OR: result = fileVal | workRegister;
      default:
      begin
        isFileOp = 1'b0;
        updZero = 1'b0;
      end
    endcase
    // bit test shares the skip path
    if (grpCode == GRP_SKIP_SET)
    begin
      skipNext = fileVal[instr[8:BIT_SEL_LSB]];
    end
  end

  // compare keeps both operands, clear always targets the file register
  assign toFile = isFileOp && (rgCode != RG_COMPARE)
    && (instr[DEST_POS] || rgCode == RG_ZERO_FILE);
  assign toWork = isFileOp && (rgCode != RG_COMPARE)
    && (rgCode != RG_ZERO_FILE) && !instr[DEST_POS];

  // control transfers
  always_comb
  begin
    isCall = (instr == OP_CALL_IND);
    isJump = 1'b1;
    jumpTarget = pc;
    if (instr == OP_CALL_IND || instr == OP_JUMP_IND)
      jumpTarget = {tableHighPointer[1:0], workRegister};
    else if (grpCode == GRP_JUMP_PAGED)
      jumpTarget = {pageHighLatch[PAGE_BIT_POS], instr[8:0]};
    else
      isJump = 1'b0;
  end

  // fetch sequencing: a taken branch or skip costs one dropped slot
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= DROP_ONE;
      pc <= PC_RESET;
      execAddr <= PC_RESET;
    end
    else
    begin
      execAddr <= pc;
      unique case (state)
        RUN:
        begin
          if (instr == OP_SOFT_TRAP)
          begin
            state <= TRAP_LOAD;
          end
          else if (isJump)
          begin
            pc <= jumpTarget;
            state <= DROP_ONE;
          end
          else
          begin
            pc <= pc + 10'h001;
            state <= skipNext ? DROP_ONE : RUN;
          end
        end
        // the vector load waits one slot so the trap spans three cycles
        TRAP_LOAD:
        begin
          pc <= TRAP_VECTOR;
          state <= DROP_ONE;
        end
        DROP_ONE:
        begin
          pc <= pc + 10'h001;
          state <= RUN;
        end
      endcase
    end
  end

  // return stack, wraps silently when more than eight deep
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sp <= SP_RESET;
    end
    else if (isCall || instr == OP_SOFT_TRAP)
    begin
      stackMem[sp] <= retAddr;
      sp <= sp + 3'h1;
    end
  end

  // file registers and the debug read port
  always_ff @(posedge clk)
  begin
    if (toFile)
      fileMem[fileIdx] <= result;
    peekData <= fileMem[peekAddr];
  end

  // work register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      workRegister <= DATA_RESET;
    else if (instr == OP_ZERO_WORK)
      workRegister <= DATA_RESET;
    else if (instr == OP_DEC_ADJUST)
      workRegister <= adjAll[7:0];
    else if (toWork)
      workRegister <= result;
  end

  // status flags; digit carry is only cleared by reset, nothing here writes it
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      zeroFlag <= 1'b0;
      digitCarryFlag <= 1'b0;
      carryFlag <= 1'b0;
    end
    else
    begin
      if (instr == OP_ZERO_WORK || rgCode == RG_ZERO_FILE)
        zeroFlag <= 1'b1;
      else if (updZero)
        zeroFlag <= (result == DATA_RESET);
      if (rgCode == RG_COMPARE)
        carryFlag <= cmpSum[8];
      else if (instr == OP_DEC_ADJUST)
        carryFlag <= highFix;
    end
  end

  // global interrupt enable
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      globalIrqEnable <= 1'b0;
    else if (instr == OP_IRQ_MASK)
      globalIrqEnable <= 1'b0;
    else if (instr == OP_IRQ_UNMASK)
      globalIrqEnable <= 1'b1;
  end

  // watchdog status; a timeout in the same cycle as a kick wins
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      watchdogExpiry <= 1'b1;
      sleepStatus <= 1'b1;
      watchdogClear <= 1'b0;
      dividerClear <= 1'b0;
    end
    else
    begin
      watchdogClear <= (instr == OP_KICK_WDOG);
      dividerClear <= (instr == OP_KICK_WDOG) && dividerToWatchdog;
      if (watchdogTimeout)
        watchdogExpiry <= 1'b0;
      else if (instr == OP_KICK_WDOG)
        watchdogExpiry <= 1'b1;
      if (sleepEnter)
        sleepStatus <= 1'b0;
      else if (instr == OP_KICK_WDOG)
        sleepStatus <= 1'b1;
    end
  end

  property p_skip_bit;
    @(posedge clk) disable iff (sys_rst)
    (grpCode == GRP_SKIP_SET) && fileVal[instr[8:6]] |=>
      state == DROP_ONE ##1 state == RUN;
  endproperty
  a_skip_bit: assert property (p_skip_bit)
    else $error("bit skip did not drop one slot");

  property p_call_ind;
    @(posedge clk) disable iff (sys_rst)
    instr == OP_CALL_IND |=> pc == {$past(tableHighPointer[1:0]),
      $past(workRegister)} && stackMem[sp - 3'h1] == $past(retAddr)
      && sp == $past(sp) + 3'h1;
  endproperty
  a_call_ind: assert property (p_call_ind)
    else $error("indirect call target or push wrong");

  property p_jump_ind;
    @(posedge clk) disable iff (sys_rst)
    instr == OP_JUMP_IND |=> pc[7:0] == $past(workRegister)
      && $stable(sp) && state == DROP_ONE;
  endproperty
  a_jump_ind: assert property (p_jump_ind)
    else $error("indirect jump wrong");

  property p_zero_work;
    @(posedge clk) disable iff (sys_rst)
    instr == OP_ZERO_WORK |=> workRegister == DATA_RESET && zeroFlag;
  endproperty
  a_zero_work: assert property (p_zero_work)
    else $error("work register clear failed");

  property p_kick;
    @(posedge clk) disable iff (sys_rst)
    instr == OP_KICK_WDOG && !watchdogTimeout && !sleepEnter |=>
      watchdogClear && watchdogExpiry && sleepStatus
      && dividerClear == $past(dividerToWatchdog);
  endproperty
  a_kick: assert property (p_kick)
    else $error("watchdog kick effects missing");

  property p_compare;
    @(posedge clk) disable iff (sys_rst)
    rgCode == RG_COMPARE |=> $stable(workRegister)
      && carryFlag == $past(cmpSum[8])
      && zeroFlag == ($past(cmpSum[7:0]) == DATA_RESET);
  endproperty
  a_compare: assert property (p_compare)
    else $error("compare flags wrong");

  // every executed mask lands on the next edge, whatever came before
  property p_irq_gate;
    @(posedge clk) disable iff (sys_rst)
    instr == OP_IRQ_MASK |=> !globalIrqEnable;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("global interrupt enable not cleared");

  property p_irq_unmask;
    @(posedge clk) disable iff (sys_rst)
    instr == OP_IRQ_UNMASK |=> globalIrqEnable;
  endproperty
  a_irq_unmask: assert property (p_irq_unmask)
    else $error("global interrupt enable not set");

  property p_jump_paged;
    @(posedge clk) disable iff (sys_rst)
    grpCode == GRP_JUMP_PAGED |=> pc == {$past(pageHighLatch[1]),
      $past(instr[8:0])} ##1 (live && execAddr == $past(pc));
  endproperty
  a_jump_paged: assert property (p_jump_paged)
    else $error("paged jump target wrong");

  property p_soft_trap;
    @(posedge clk) disable iff (sys_rst)
    instr == OP_SOFT_TRAP |=> !live ##1 (!live && pc == TRAP_VECTOR)
      ##1 execAddr == TRAP_VECTOR && live;
  endproperty
  a_soft_trap: assert property (p_soft_trap)
    else $error("soft trap sequence wrong");

  property p_flags_kept;
    @(posedge clk) disable iff (sys_rst)
    instr == OP_IRQ_UNMASK || rgCode == RG_INC_SKIP |=>
      $stable(zeroFlag) && $stable(carryFlag) && $stable(digitCarryFlag);
  endproperty
  a_flags_kept: assert property (p_flags_kept)
    else $error("flags changed by flagless instruction");

  c_skip_taken: cover property (@(posedge clk) disable iff (sys_rst)
    rgCode == RG_DEC_SKIP && skipNext);
  c_trap: cover property (@(posedge clk) disable iff (sys_rst)
    instr == OP_SOFT_TRAP);
  c_call: cover property (@(posedge clk) disable iff (sys_rst)
    isCall ##3 instr == OP_JUMP_IND);
  c_adjust: cover property (@(posedge clk) disable iff (sys_rst)
    instr == OP_DEC_ADJUST && highFix);
endmodule // mies_core

// ---- testbench/mies_prog_mem.sv ----
`timescale 1ns/1ps
module mies_prog_mem (
  input wire logic clk,
  input wire logic [mies_pkg::PC_WIDTH-1:0] progAddr,
  output logic [mies_pkg::INSTR_WIDTH-1:0] progData,
  input wire logic loadEn,
  input wire logic [mies_pkg::PC_WIDTH-1:0] loadAddr,
  input wire logic [mies_pkg::INSTR_WIDTH-1:0] loadWord
);
  import mies_pkg::*;
  logic [INSTR_WIDTH-1:0] mem [0:1023];
  // blank words read as nop, so a stray fetch changes nothing visible
  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem[i] = OP_NOP;
  end
  // one cycle of read latency; loading is only safe while the core is reset
  always @(posedge clk)
  begin
    if (loadEn)
      mem[loadAddr] <= loadWord;
    progData <= mem[progAddr];
  end
endmodule // mies_prog_mem

// ---- testbench/mies_core_tb_top.sv ----
`timescale 1ns/1ps
module mies_core_tb_top;
  import mies_pkg::*;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [9:0] progAddr;
  logic [13:0] progData;
  logic [7:0] tableHighPointer = 8'h00;
  logic [7:0] pageHighLatch = 8'h00;
  logic dividerToWatchdog = 1'h0;
  logic watchdogTimeout = 1'h0;
  logic sleepEnter = 1'h0;
  logic [5:0] peekAddr = 6'h00;
  logic [7:0] peekData, workRegister;
  logic zeroFlag, digitCarryFlag, carryFlag, globalIrqEnable;
  logic watchdogExpiry, sleepStatus, watchdogClear, dividerClear;
  logic loadEn = 1'h0;
  logic [9:0] loadAddr = 10'h000;
  logic [13:0] loadWord = 14'h0000;
  logic [9:0] wa = 10'h000;
  int badCount = 0;
  int nCompared = 0;
  int cyc = 0;
  int total = 0;

  // core and its program memory
  mies_core dut_u (.clk(clk), .sys_rst(sys_rst), .progAddr(progAddr),
    .progData(progData), .tableHighPointer(tableHighPointer),
    .pageHighLatch(pageHighLatch), .dividerToWatchdog(dividerToWatchdog),
    .watchdogTimeout(watchdogTimeout), .sleepEnter(sleepEnter),
    .peekAddr(peekAddr), .peekData(peekData), .workRegister(workRegister),
    .zeroFlag(zeroFlag), .digitCarryFlag(digitCarryFlag),
    .carryFlag(carryFlag), .globalIrqEnable(globalIrqEnable),
    .watchdogExpiry(watchdogExpiry), .sleepStatus(sleepStatus),
    .watchdogClear(watchdogClear), .dividerClear(dividerClear));
  mies_prog_mem mem_u (.clk(clk), .progAddr(progAddr), .progData(progData),
    .loadEn(loadEn), .loadAddr(loadAddr), .loadWord(loadWord));

  initial
    forever #5 clk = ~clk;

  // cycles since release give exact branch timing; total cuts a hang
  always @(posedge clk)
  begin
    cyc <= sys_rst ? 0 : cyc + 1;
    total <= total + 1;
    if (total == 2000)
    begin
      badCount++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(string name, logic [9:0] seen, logic [9:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      badCount++;
    end
  endtask

  // loading holds the core in reset, so each program starts clean
  task automatic pw(logic [13:0] w);
    @(posedge clk);
    sys_rst <= 1'h1;
    loadEn <= 1'h1;
    loadAddr <= wa;
    loadWord <= w;
    wa = wa + 10'h001;
  endtask

  task automatic fr(logic [6:0] c, logic d, logic [5:0] r);
    pw({c, d, r});
  endtask

  task automatic go();
    @(posedge clk);
    loadEn <= 1'h0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
  endtask

  // skips drop a word but never stall fetch, so pc still marks each slot
  task automatic atPc(logic [9:0] a, output int t);
    int n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (progAddr !== a && n < 60);
    check("pc", progAddr, a);
    t = cyc;
  endtask

  task automatic stAt(logic [9:0] a, logic [7:0] w, logic z, logic c,
    logic ie);
    int t;
    atPc(a, t);
    check("work", 10'(workRegister), 10'(w));
    check("zero", 10'(zeroFlag), 10'(z));
    check("carry", 10'(carryFlag), 10'(c));
    check("dcarry", 10'(digitCarryFlag), 10'h000);
    check("irqen", 10'(globalIrqEnable), 10'(ie));
  endtask

  task automatic wd(logic wc, logic dc, logic ex, logic sl);
    check("wdclr", 10'(watchdogClear), 10'(wc));
    check("divclr", 10'(dividerClear), 10'(dc));
    check("expiry", 10'(watchdogExpiry), 10'(ex));
    check("sleep", 10'(sleepStatus), 10'(sl));
  endtask

  // the program parks in a self loop, so the file array is stable here
  task automatic pk(logic [5:0] r, logic [7:0] v);
    @(posedge clk);
    peekAddr <= r;
    @(posedge clk);
    #1;
    check("file", 10'(peekData), 10'(v));
  endtask

  task automatic s_arith();
    wa = 10'h000;
    fr(RG_ZERO_FILE, 1'h0, 6'h05);
    fr(RG_DEC, 1'h1, 6'h05);
    fr(RG_INVERT, 1'h0, 6'h05);
    fr(RG_DEC, 1'h0, 6'h05);
    fr(RG_ZERO_FILE, 1'h0, 6'h06);
    fr(RG_OR, 1'h1, 6'h06);
    fr(RG_COMPARE, 1'h0, 6'h05);
    fr(RG_INC, 1'h0, 6'h06);
    fr(RG_COMPARE, 1'h0, 6'h06);
    pw(OP_IRQ_UNMASK);
    pw(OP_DEC_ADJUST);
    pw(OP_ZERO_WORK);
    pw(OP_IRQ_MASK);
    pw({GRP_JUMP_PAGED, 9'h00D});
    go();
    stAt(10'h002, 8'h00, 1'h1, 1'h0, 1'h0);
    stAt(10'h003, 8'h00, 1'h0, 1'h0, 1'h0);
    stAt(10'h004, 8'h00, 1'h1, 1'h0, 1'h0);
    stAt(10'h005, 8'hFE, 1'h0, 1'h0, 1'h0);
    stAt(10'h007, 8'hFE, 1'h0, 1'h0, 1'h0);
    stAt(10'h008, 8'hFE, 1'h0, 1'h1, 1'h0);
    stAt(10'h009, 8'hFF, 1'h0, 1'h1, 1'h0);
    stAt(10'h00A, 8'hFF, 1'h0, 1'h0, 1'h0);
    stAt(10'h00B, 8'hFF, 1'h0, 1'h0, 1'h1);
    stAt(10'h00C, 8'h65, 1'h0, 1'h1, 1'h1);
    stAt(10'h00D, 8'h00, 1'h1, 1'h1, 1'h1);
    stAt(10'h00E, 8'h00, 1'h1, 1'h1, 1'h0);
    pk(6'h05, 8'hFF);
    pk(6'h06, 8'hFE);
  endtask

  // each dropped slot holds an interrupt enable change that must not land
  task automatic s_skip();
    wa = 10'h000;
    fr(RG_ZERO_FILE, 1'h0, 6'h07);
    fr(RG_INC, 1'h1, 6'h07);
    pw({GRP_SKIP_SET, 3'h0, 6'h07});
    pw(OP_IRQ_UNMASK);
    pw({GRP_SKIP_SET, 3'h1, 6'h07});
    pw(OP_IRQ_UNMASK);
    fr(RG_DEC_SKIP, 1'h1, 6'h07);
    pw(OP_IRQ_MASK);
    fr(RG_INC_SKIP, 1'h0, 6'h07);
    pw(OP_IRQ_MASK);
    fr(RG_DEC_SKIP, 1'h0, 6'h07);
    fr(RG_INVERT, 1'h1, 6'h07);
    fr(RG_INC_SKIP, 1'h1, 6'h07);
    pw(OP_IRQ_UNMASK);
    pw({GRP_JUMP_PAGED, 9'h00E});
    go();
    stAt(10'h005, 8'h00, 1'h0, 1'h0, 1'h0);
    stAt(10'h007, 8'h00, 1'h0, 1'h0, 1'h1);
    stAt(10'h009, 8'h00, 1'h0, 1'h0, 1'h1);
    stAt(10'h00A, 8'h01, 1'h0, 1'h0, 1'h1);
    stAt(10'h00B, 8'h01, 1'h0, 1'h0, 1'h0);
    stAt(10'h00C, 8'hFF, 1'h0, 1'h0, 1'h0);
    stAt(10'h00F, 8'hFF, 1'h0, 1'h0, 1'h0);
    pk(6'h07, 8'h00);
  endtask

  // latch bit 1 and immediate bit 8 both reach the target address
  task automatic s_branch();
    int t;
    wa = 10'h000;
    pw({GRP_JUMP_PAGED, 9'h110});
    pageHighLatch <= 8'h02;
    tableHighPointer <= 8'hFE;
    watchdogTimeout <= 1'h1;
    sleepEnter <= 1'h1;
    pw({GRP_JUMP_PAGED, 9'h001});
    wa = 10'h310;
    pw(OP_KICK_WDOG);
    fr(RG_ZERO_FILE, 1'h0, 6'h09);
    fr(RG_DEC, 1'h1, 6'h09);
    fr(RG_DEC, 1'h0, 6'h09);
    pw(OP_JUMP_IND);
    wa = 10'h2FE;
    pw(OP_KICK_WDOG);
    fr(RG_INC, 1'h0, 6'h09);
    pw(OP_CALL_IND);
    wa = 10'h200;
    pw(OP_SOFT_TRAP);
    pw({GRP_JUMP_PAGED, 9'h001});
    go();
    @(posedge clk);
    watchdogTimeout <= 1'h0;
    sleepEnter <= 1'h0;
    atPc(10'h310, t);
    check("cycles", 10'(t), 10'h002);
    atPc(10'h311, t);
    wd(1'h0, 1'h0, 1'h0, 1'h0);
    atPc(10'h312, t);
    wd(1'h1, 1'h0, 1'h1, 1'h1);
    atPc(10'h313, t);
    wd(1'h0, 1'h0, 1'h1, 1'h1);
    @(posedge clk);
    dividerToWatchdog <= 1'h1;
    atPc(10'h2FE, t);
    check("cycles", 10'(t), 10'h008);
    atPc(10'h300, t);
    wd(1'h1, 1'h1, 1'h1, 1'h1);
    atPc(10'h200, t);
    check("cycles", 10'(t), 10'h00C);
    atPc(10'h001, t);
    check("cycles", 10'(t), 10'h00F);
    atPc(10'h201, t);
    check("cycles", 10'(t), 10'h011);
  endtask

  initial
  begin
    s_arith();
    s_skip();
    s_branch();
    wrap_up();
  end
endmodule // mies_core_tb_top
